/* File: pkg/three_wire_pkg.sv */
// constants shared by the three-wire serial port controller
package three_wire_pkg;

    // ==========================================================
    // core clock and serial clock timing
    localparam int CORE_PERIOD_PS = 5000;
    // fastest allowed serial clock is 19.2 MHz; its period in ps, rounded up
    localparam int SCLK_MIN_PERIOD_PS = 52084;
    // each half period is a least time, so round up
    localparam int HALF_CYCLES_INT = (SCLK_MIN_PERIOD_PS / 2 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    localparam logic [2:0] HALF_CYCLES = 3'(HALF_CYCLES_INT);

    // ==========================================================
    // hard reset pulse: at least 100 ns low
    localparam int HARD_RESET_MIN_NS = 100;
    localparam int HARD_RESET_CYCLES_INT =
        (HARD_RESET_MIN_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    localparam logic [4:0] HARD_RESET_CYCLES = 5'(HARD_RESET_CYCLES_INT);

    // ==========================================================
    // frame layout
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 16;
    localparam logic START_BIT = 1'b1;
    localparam logic OP_WRITE = 1'b0;
    localparam logic OP_READ = 1'b1;

    // falling edge numbers: falling edge k follows rising edge k
    localparam logic [4:0] FALL_SELECT_LOW = 5'h01;
    localparam logic [4:0] FALL_OP = 5'h02;
    localparam logic [4:0] FALL_ADDR_FIRST = 5'h03;
    localparam logic [4:0] FALL_ADDR_LAST = 5'h09;
    localparam logic [4:0] FALL_PAYLOAD_FIRST = 5'h0a;
    localparam logic [4:0] FALL_PAYLOAD_LAST = 5'h19;
    localparam logic [4:0] FALL_WR_SELECT_HIGH = 5'h1a;
    localparam logic [4:0] WR_LAST_EDGE = 5'h1b;
    localparam logic [4:0] FALL_RD_RELEASE = 5'h0a;
    localparam logic [4:0] RD_FIRST_CAPTURE = 5'h0d;
    localparam logic [4:0] RD_LAST_CAPTURE = 5'h1c;
    localparam logic [4:0] RD_LAST_EDGE = 5'h1d;

    // ==========================================================
    // reset values of pins
    localparam logic SELECT_IDLE = 1'b1;
    localparam logic SCLK_IDLE = 1'b0;

endpackage

/* File: design/sync_two_ff.sv */
// two-flop synchroniser for levels arriving from a pin
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.meta = din;
        next_s.stable = s.meta;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign dout = s.stable;

endmodule

`default_nettype wire

/* File: design/three_wire_host.sv */
// controller that drives the three-wire serial port of the synthesizer chip
//
// Overview of operation
// - between frames select rests high and the data line is released
// - start the serial clock, pull select low on its first falling edge
// - rising edge two carries the start bit, edge three the operation bit
// - operation bit zero marks a write
// - operation bit one marks a read
// - seven address bits follow the operation bit, most significant first
// - a write carries sixteen payload bits, 25 bits total, controller drives all
// - serial clock never runs faster than 19.2 MHz
// - one extra rising edge is issued before select goes low
// - in a read the controller drives only start, operation and address
// - a turnaround of two and a half clocks precedes read data
// - device changes read data on rising edges, controller samples on falling
// - device drives from three rising edges after the last address bit
// - after the last read bit select rises, and the device releases on that rise
`timescale 1ns/1ps
`default_nettype none

module three_wire_host (
    input wire logic core_clk,
    input wire logic arst_n,
    // user side
    input wire logic startReq,
    input wire logic isRead,
    input wire logic [6:0] regAddr,
    input wire logic [15:0] wrData,
    input wire logic chipEnableReq,
    input wire logic modeReq,
    input wire logic hardResetReq,
    output logic busy,
    output logic done,
    output logic [15:0] rdData,
    // device pins
    output logic sclk,
    output logic selectN,
    output logic sdataOut,
    output logic sdataOe,
    input wire logic sdataIn,
    output logic chipEnablePin,
    output logic modeSelect,
    output logic hardResetN
);

    // ==========================================================
    // state
    typedef enum logic [1:0] {
        IDLE,
        RUN
    } ctl_state_t;

    typedef struct packed {
        ctl_state_t st;
        logic [2:0] phase;
        logic [4:0] edgeCnt;
        logic sclk;
        logic selN;
        logic oe;
        logic dout;
        logic isRd;
        logic [6:0] addr;
        logic [6:0] addrCopy;
        logic [15:0] shift;
        logic [15:0] rdData;
        logic busy;
        logic done;
        logic [4:0] rstCnt;
        logic hardResetN;
        logic chipEnable;
        logic mode;
    } host_state_t;

    localparam host_state_t RESET_STATE = '{
        st: IDLE,
        phase: 3'h0,
        edgeCnt: 5'h00,
        sclk: three_wire_pkg::SCLK_IDLE,
        selN: three_wire_pkg::SELECT_IDLE,
        oe: 1'b0,
        dout: 1'b0,
        isRd: 1'b0,
        addr: 7'h00,
        addrCopy: 7'h00,
        shift: 16'h0000,
        rdData: 16'h0000,
        busy: 1'b0,
        done: 1'b0,
        rstCnt: 5'h00,
        hardResetN: 1'b1,
        chipEnable: 1'b0,
        mode: 1'b0
    };

    host_state_t s;
    host_state_t next_s;
    logic sdataSync;

    // ==========================================================
    // input synchroniser: the data line is owned by the device during reads
    sync_two_ff #(
        .WIDTH(1)
    ) sync_two_ff_inst (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .din(sdataIn),
        .dout(sdataSync)
    );

    // ==========================================================
    // next state
    always_comb
    begin
        logic [4:0] k;
        logic lastEdge;
        k = s.edgeCnt;
        lastEdge = 1'b0;
        next_s = s;
        next_s.done = 1'b0;
        next_s.chipEnable = chipEnableReq;
        next_s.mode = modeReq;

        // hard reset pulse held long enough for the device to clear all registers
        if (hardResetReq && s.rstCnt == 5'h00 && s.st == IDLE)
        begin
            next_s.rstCnt = three_wire_pkg::HARD_RESET_CYCLES;
        end
        else if (s.rstCnt != 5'h00)
        begin
            next_s.rstCnt = s.rstCnt - 5'h01;
        end
        next_s.hardResetN = (next_s.rstCnt == 5'h00);

        unique case (s.st)
            IDLE:
            begin
                next_s.sclk = three_wire_pkg::SCLK_IDLE;
                next_s.selN = three_wire_pkg::SELECT_IDLE;
                next_s.oe = 1'b0;
                if (startReq && s.rstCnt == 5'h00)
                begin
                    next_s.st = RUN;
                    next_s.phase = 3'h0;
                    next_s.edgeCnt = 5'h00;
                    next_s.isRd = isRead;
                    next_s.addr = regAddr;
                    next_s.addrCopy = regAddr;
                    next_s.shift = wrData;
                    next_s.busy = 1'b1;
                end
            end
            RUN:
            begin
                if (s.phase != three_wire_pkg::HALF_CYCLES - 3'h1)
                begin
                    next_s.phase = s.phase + 3'h1;
                end
                else if (!s.sclk)
                begin
                    // rising edge; the first one comes while select is still high
                    next_s.phase = 3'h0;
                    next_s.sclk = 1'b1;
                    next_s.edgeCnt = s.edgeCnt + 5'h01;
                end
                else
                begin
                    next_s.phase = 3'h0;
                    next_s.sclk = 1'b0;
                    if (k == three_wire_pkg::FALL_SELECT_LOW)
                    begin
                        next_s.selN = 1'b0;
                        next_s.oe = 1'b1;
                        next_s.dout = three_wire_pkg::START_BIT;
                    end
                    if (k == three_wire_pkg::FALL_OP)
                    begin
                        next_s.dout = s.isRd ? three_wire_pkg::OP_READ
                                             : three_wire_pkg::OP_WRITE;
                    end
                    if (k >= three_wire_pkg::FALL_ADDR_FIRST && k <= three_wire_pkg::FALL_ADDR_LAST)
                    begin
                        next_s.dout = s.addr[6];
                        next_s.addr = {s.addr[5:0], 1'b0};
                    end
                    if (!s.isRd)
                    begin
                        if (k >= three_wire_pkg::FALL_PAYLOAD_FIRST &&
                            k <= three_wire_pkg::FALL_PAYLOAD_LAST)
                        begin
                            next_s.dout = s.shift[15];
                            next_s.shift = {s.shift[14:0], 1'b0};
                        end
                        if (k == three_wire_pkg::FALL_WR_SELECT_HIGH)
                        begin
                            // one more rising edge follows so the device commits
                            next_s.selN = 1'b1;
                            next_s.oe = 1'b0;
                        end
                        lastEdge = (k == three_wire_pkg::WR_LAST_EDGE);
                    end
                    else
                    begin
                        if (k == three_wire_pkg::FALL_RD_RELEASE)
                        begin
                            // released half a clock after the last address bit
                            next_s.oe = 1'b0;
                        end
                        if (k >= three_wire_pkg::RD_FIRST_CAPTURE &&
                            k <= three_wire_pkg::RD_LAST_CAPTURE)
                        begin
                            next_s.shift = {s.shift[14:0], sdataSync};
                        end
                        if (k == three_wire_pkg::RD_LAST_CAPTURE)
                        begin
                            next_s.rdData = {s.shift[14:0], sdataSync};
                            next_s.selN = 1'b1;
                        end
                        lastEdge = (k == three_wire_pkg::RD_LAST_EDGE);
                    end
                    if (lastEdge)
                    begin
                        next_s.st = IDLE;
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                        next_s.selN = 1'b1;
                        next_s.oe = 1'b0;
                    end
                end
            end
            default:
            begin
                next_s = RESET_STATE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= RESET_STATE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign busy = s.busy;
    assign done = s.done;
    assign rdData = s.rdData;
    assign sclk = s.sclk;
    assign selectN = s.selN;
    assign sdataOut = s.dout;
    assign sdataOe = s.oe;
    assign chipEnablePin = s.chipEnable;
    assign modeSelect = s.mode;
    assign hardResetN = s.hardResetN;

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    property p_idle_rest;
        s.st == IDLE && !$past(s.st == RUN) |-> selectN && !sdataOe;
    endproperty
    a_idle_rest: assert property (p_idle_rest) else $error("bus not at rest when idle");

    property p_select_on_fall;
        $fell(selectN) |-> $fell(sclk) && s.edgeCnt == 5'h01;
    endproperty
    a_select_on_fall: assert property (p_select_on_fall) else $error("select fell off edge");

    property p_start_bit;
        $rose(sclk) && s.edgeCnt == 5'h02 |-> sdataOe && sdataOut == three_wire_pkg::START_BIT;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit wrong");

    property p_write_op;
        $rose(sclk) && s.edgeCnt == 5'h03 && !s.isRd |-> sdataOe && !sdataOut;
    endproperty
    a_write_op: assert property (p_write_op) else $error("write op bit wrong");

    property p_read_op;
        $rose(sclk) && s.edgeCnt == 5'h03 && s.isRd |-> sdataOe && sdataOut;
    endproperty
    a_read_op: assert property (p_read_op) else $error("read op bit wrong");

    property p_addr_msb_first;
        $rose(sclk) && s.edgeCnt >= 5'h04 && s.edgeCnt <= 5'h0a
            |-> sdataOut == s.addrCopy[3'(5'h0a - s.edgeCnt)];
    endproperty
    a_addr_msb_first: assert property (p_addr_msb_first) else $error("address bit wrong");

    property p_write_driven;
        $rose(sclk) && !s.isRd && s.edgeCnt >= 5'h02 && s.edgeCnt <= 5'h1a |-> sdataOe && !selectN;
    endproperty
    a_write_driven: assert property (p_write_driven) else $error("write not driven");

    property p_clock_rate;
        $rose(sclk) |-> sclk[*6] ##1 !sclk[*6];
    endproperty
    a_clock_rate: assert property (p_clock_rate) else $error("serial clock too fast");

    property p_extra_edge;
        $rose(sclk) && s.edgeCnt == 5'h01 |-> selectN ##6 $fell(sclk) ##1 !selectN;
    endproperty
    a_extra_edge: assert property (p_extra_edge) else $error("no edge before select");

    property p_read_released;
        $rose(sclk) && s.isRd && s.edgeCnt >= 5'h0b |-> !sdataOe;
    endproperty
    a_read_released: assert property (p_read_released) else $error("driving during read");

    property p_turnaround;
        $fell(sdataOe) && s.isRd |-> !sclk && s.edgeCnt == 5'h0a;
    endproperty
    a_turnaround: assert property (p_turnaround) else $error("turnaround misplaced");

    property p_capture_on_fall;
        s.st == RUN && $past(s.st) == RUN && s.isRd && $changed(s.shift) |-> $fell(sclk);
    endproperty
    a_capture_on_fall: assert property (p_capture_on_fall) else $error("capture off edge");

    property p_hiz_before_device;
        $rose(sclk) && s.isRd && s.edgeCnt == 5'h0d |-> !sdataOe && $past(!sdataOe, 6);
    endproperty
    a_hiz_before_device: assert property (p_hiz_before_device) else $error("not released");

    property p_read_end;
        $rose(selectN) && s.isRd |-> $fell(sclk) && s.edgeCnt == 5'h1c && !sdataOe;
    endproperty
    a_read_end: assert property (p_read_end) else $error("read end misplaced");

    property p_hard_reset_len;
        $fell(hardResetN) |-> !hardResetN[*8];
    endproperty
    a_hard_reset_len: assert property (p_hard_reset_len) else $error("hard reset short");

    c_write: cover property (done && !s.isRd);
    c_read: cover property (done && s.isRd);
    c_hard_reset: cover property ($rose(hardResetN));

endmodule

`default_nettype wire

/* File: verification/three_wire_device_model.sv */
// behavioural model of the synthesizer chip behind the three-wire port
`timescale 1ns/1ps
`default_nettype none

module three_wire_device_model #(
    parameter logic [15:0] GENERAL_RESET = 16'h0000,
    parameter logic [15:0] MIXER_RESET = 16'h8400,
    parameter logic [15:0] OSC_RESET = 16'h0400
) (
    input wire logic core_clk,
    input wire logic sclk,
    input wire logic selectN,
    input wire logic sdataOut,
    input wire logic sdataOe,
    output logic sdataIn,
    input wire logic chipEnablePin,
    input wire logic modeSelect,
    input wire logic hardResetN,
    output logic oscRunning,
    output logic mixerOneOn,
    output logic mixerTwoOn,
    output logic periodErr,
    output logic edgeErr,
    output logic clash
);
    // ==========================================================
    // register file and frame state
    logic [15:0] regFile [0:127];
    logic [4:0] edgeCnt = 5'h00;
    logic inFrame = 1'b0;
    logic roseIdle = 1'b0;
    logic opBit = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [15:0] shiftIn = 16'h0000;
    logic [15:0] rdWord = 16'h0000;
    logic devOe = 1'b0;
    logic devOut = 1'b0;
    logic floatVal = 1'b0;
    realtime lastRise = -1000.0;

    task automatic load_defaults();
        for (int i = 0; i < 128; i++)
            regFile[i] = 16'h0000;
        regFile[0] = GENERAL_RESET;
        regFile[1] = MIXER_RESET;
        regFile[3] = OSC_RESET;
    endtask

    initial
    begin
        periodErr = 1'b0;
        edgeErr = 1'b0;
        clash = 1'b0;
        load_defaults();
    end

    always @(negedge hardResetN)
    begin
        load_defaults();
        inFrame = 1'b0;
        devOe = 1'b0;
    end

    // ==========================================================
    // serial frame decoding
    always @(negedge selectN)
    begin
        // select may only fall after an idle rising edge
        if (!roseIdle)
            edgeErr = 1'b1;
        roseIdle = 1'b0;
        inFrame = 1'b1;
        edgeCnt = 5'h00;
    end

    always @(posedge selectN)
    begin
        devOe = 1'b0;
    end

    always @(posedge sclk)
    begin
        if ($realtime - lastRise < 52.08)
            periodErr = 1'b1;
        lastRise = $realtime;
        if (selectN && inFrame)
        begin
            // a write cut short never reaches 25 bits, so it is dropped
            if (!opBit && edgeCnt == 5'h19)
                regFile[addr] = shiftIn;
            inFrame = 1'b0;
            devOe = 1'b0;
        end
        else if (selectN)
            roseIdle = 1'b1;
        else if (inFrame)
        begin
            edgeCnt = edgeCnt + 5'h01;
            if (edgeCnt == 5'h02)
                opBit = sdataIn;
            else if (edgeCnt > 5'h02 && edgeCnt <= 5'h09)
                addr = {addr[5:0], sdataIn};
            else if (!opBit)
                shiftIn = {shiftIn[14:0], sdataIn};
            if (opBit && edgeCnt == 5'h09)
                rdWord = regFile[addr];
            if (opBit && edgeCnt >= 5'h0c && edgeCnt <= 5'h1b)
            begin
                devOe = 1'b1;
                devOut = rdWord[5'h1b - edgeCnt];
            end
        end
    end

    // ==========================================================
    // line level: an undriven line wanders every cycle
    always @(posedge core_clk)
    begin
        floatVal <= ~floatVal;
        if (sdataOe && devOe)
            clash <= 1'b1;
    end

    assign sdataIn = sdataOe ? sdataOut : (devOe ? devOut : floatVal);
    assign oscRunning = chipEnablePin | regFile[2][0];
    assign mixerOneOn = regFile[0][1] | !modeSelect;
    assign mixerTwoOn = regFile[0][1] | modeSelect;
endmodule
`default_nettype wire

/* File: verification/three_wire_control_port_bench.sv */
// self-checking bench for the three-wire port controller
`timescale 1ns/1ps
`default_nettype none

module three_wire_control_port_bench;
    localparam logic [15:0] GEN_DEF = 16'h0000;
    localparam logic [15:0] MIX_DEF = 16'h8400;
    localparam logic [15:0] OSC_DEF = 16'h0400;
    localparam int PERIOD = 2 * three_wire_pkg::HALF_CYCLES_INT;

    logic core_clk = 1'b0;
    logic arst_n, startReq, isRead, chipEnableReq, modeReq, hardResetReq;
    logic [6:0] regAddr;
    logic [15:0] wrData, rdData;
    logic busy, done, sclk, selectN, sdataOut, sdataOe, sdataIn;
    logic chipEnablePin, modeSelect, hardResetN;
    logic oscRunning, mixerOneOn, mixerTwoOn, periodErr, edgeErr, clash;
    int mismatches = 0;
    int compares = 0;
    logic [15:0] shadow [0:127];

    always #2.5 core_clk = ~core_clk;

    three_wire_host three_wire_host_inst (.core_clk(core_clk), .arst_n(arst_n),
        .startReq(startReq), .isRead(isRead), .regAddr(regAddr), .wrData(wrData),
        .chipEnableReq(chipEnableReq), .modeReq(modeReq), .hardResetReq(hardResetReq),
        .busy(busy), .done(done), .rdData(rdData), .sclk(sclk), .selectN(selectN),
        .sdataOut(sdataOut), .sdataOe(sdataOe), .sdataIn(sdataIn),
        .chipEnablePin(chipEnablePin), .modeSelect(modeSelect), .hardResetN(hardResetN));

    three_wire_device_model #(.GENERAL_RESET(GEN_DEF), .MIXER_RESET(MIX_DEF),
        .OSC_RESET(OSC_DEF)) three_wire_device_model_inst (.core_clk(core_clk),
        .sclk(sclk), .selectN(selectN), .sdataOut(sdataOut), .sdataOe(sdataOe),
        .sdataIn(sdataIn), .chipEnablePin(chipEnablePin), .modeSelect(modeSelect),
        .hardResetN(hardResetN), .oscRunning(oscRunning), .mixerOneOn(mixerOneOn),
        .mixerTwoOn(mixerTwoOn), .periodErr(periodErr), .edgeErr(edgeErr), .clash(clash));

    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic reset_shadow();
        for (int i = 0; i < 128; i++)
            shadow[i] = 16'h0000;
        shadow[0] = GEN_DEF;
        shadow[1] = MIX_DEF;
        shadow[3] = OSC_DEF;
    endtask

    // done shows right after the last falling edge, counted from the take edge
    function automatic int frame_cycles(input logic rd);
        return (rd ? 29 : 27) * PERIOD;
    endfunction

    // one frame; reads are compared against the shadow copy
    task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] d);
        int cyc;
        int busyCycles;
        cyc = 0;
        busyCycles = 0;
        @(posedge core_clk);
        startReq <= 1'b1;
        isRead <= rd;
        regAddr <= a;
        wrData <= d;
        @(posedge core_clk);
        startReq <= 1'b0;
        while (done !== 1'b1 && cyc < 500)
        begin
            @(posedge core_clk);
            #1;
            cyc++;
            if (busy === 1'b1)
                busyCycles++;
        end
        check(16'(cyc), 16'(frame_cycles(rd)));
        check(16'(busyCycles), 16'(frame_cycles(rd) - 1));
        check({14'h0000, selectN, sdataOe}, 16'h0002);
        if (rd)
            check(rdData, shadow[a]);
        else
            shadow[a] = d;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        int low;
        arst_n = 1'b0;
        startReq = 1'b0;
        isRead = 1'b0;
        regAddr = 7'h00;
        wrData = 16'h0000;
        chipEnableReq = 1'b0;
        modeReq = 1'b0;
        hardResetReq = 1'b0;
        reset_shadow();
        void'($urandom(43));
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
            frame(1'b1, 7'(i), 16'h0000);
        frame(1'b0, 7'h7f, 16'hffff);
        frame(1'b0, 7'h40, 16'h8001);
        frame(1'b1, 7'h7f, 16'h0000);
        frame(1'b1, 7'h40, 16'h0000);
        for (int i = 0; i < 12; i++)
        begin
            frame(1'b0, 7'($urandom), 16'($urandom));
            frame(1'b1, 7'($urandom), 16'h0000);
        end
        // standby and duplex bits against every enable and mode level
        for (int s = 0; s < 16; s++)
        begin
            if (s % 4 == 0)
            begin
                frame(1'b0, 7'h02, {15'h0000, s[2]});
                frame(1'b0, 7'h00, {14'h0000, s[3], 1'b0});
            end
            @(posedge core_clk);
            chipEnableReq <= s[0];
            modeReq <= s[1];
            repeat (3) @(posedge core_clk);
            #1;
            check({11'h000, chipEnablePin, modeSelect, oscRunning, mixerOneOn, mixerTwoOn},
                {11'h000, s[0], s[1], s[0] | s[2], s[3] | ~s[1], s[3] | s[1]});
        end
        frame(1'b0, 7'h03, 16'hbeef);
        @(posedge core_clk);
        hardResetReq <= 1'b1;
        @(posedge core_clk);
        hardResetReq <= 1'b0;
        low = 0;
        // the pulse starts at the take edge, so sample that cycle too
        repeat (40)
        begin
            #1;
            if (hardResetN === 1'b0)
                low++;
            @(posedge core_clk);
        end
        check(16'(low), 16'(three_wire_pkg::HARD_RESET_CYCLES_INT));
        reset_shadow();
        for (int i = 0; i < 4; i++)
            frame(1'b1, 7'(i), 16'h0000);
        check({13'h0000, periodErr, edgeErr, clash}, 16'h0000);
        tally_and_finish();
    end

    // ==========================================================
    // watchdog: about four times the expected run
    initial
    begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
